// ===== pfm_pkg.sv
// Package of constants for the port function multiplexer
package pfm_pkg;
    // Function select codes per port bit
    localparam logic [1:0] FN_PORT = 2'h0;
    localparam logic [1:0] FN_SECOND = 2'h1;
    localparam logic [1:0] FN_THIRD = 2'h2;
    // Edge select codes for maskable interrupts
    localparam logic EDGE_RISE = 1'h0;
    localparam logic EDGE_FALL = 1'h1;
    // Reset values
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic RST_SYNC_RST = 1'h0;
    // Port widths
    localparam int P0_W = 8;
    localparam int P1_W = 2;
    localparam int P2_W = 3;
    localparam int P3_W = 6;
    localparam int P4_W = 8;
    // Bit positions on port 4
    localparam int P4_SDA = 0;
    localparam int P4_SCL = 1;
    localparam int P4_RXD = 2;
    localparam int P4_TXD = 3;
    localparam int P4_CKA = 4;
    localparam int P4_CKB = 5;
    localparam int P4_CKC = 6;
    localparam int P4_PB = 7;
    // Bit positions elsewhere
    localparam int P0_RXD = 2;
    localparam int P3_PC = 0;
    localparam int P3_PA = 4;
    localparam int P3_PB = 5;
    localparam int P2_SLOW = 0;
    localparam int P2_FAST = 1;
    localparam int P2_TONE = 2;
endpackage : pfm_pkg

// ===== pfm_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pfm_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // First stage read only by second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule : pfm_sync
`default_nettype wire

// ===== pfm_edge.sv
// Per-bit edge detector for interrupt pins
`timescale 1ns/1ps
`default_nettype none
module pfm_edge #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] lvl,
    input wire logic [W-1:0] en,
    input wire logic [W-1:0] fall_sel,
    input wire logic [W-1:0] both,
    output logic [W-1:0] pulse
);
    logic [W-1:0] prev_ff;
    logic [W-1:0] pulse_ff;

    // Previous level store
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= lvl;
        end
    end

    // Per-bit edge qualification
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                pulse_ff[i] <= 1'h0;
            end else if (both[i]) begin
                pulse_ff[i] <= en[i] & (lvl[i] ^ prev_ff[i]);
            end else if (fall_sel[i]) begin
                pulse_ff[i] <= en[i] & prev_ff[i] & ~lvl[i];
            end else begin
                pulse_ff[i] <= en[i] & ~prev_ff[i] & lvl[i];
            end
        end
        // Both-edge bit: any level change while enabled must give a request
        sequence s_lvl_change;
            both[i] && en[i] && (lvl[i] != $past(lvl[i]));
        endsequence
        property p_both_edge;
            @(posedge clk) disable iff (!arst_n)
            s_lvl_change |=> pulse[i];
        endproperty
        a_both_edge: assert property (p_both_edge)
            else $error("both-edge request missed");
        // A bit masked in the last cycle never requests
        property p_irq_masked;
            @(posedge clk) disable iff (!arst_n)
            !$past(en[i]) |-> !pulse[i];
        endproperty
        a_irq_masked: assert property (p_irq_masked)
            else $error("masked request fired");
    end
    assign pulse = pulse_ff;
endmodule : pfm_edge
`default_nettype wire

// ===== pfm_port_mux.sv
// Port function multiplexer top: pins to peripherals and interrupts
//
// Operation
// - Reset low holds system reset asserted
// - Reset release lets program execution begin
// - Alternate function takes pin from port
// - Non-maskable pin requests on both edges
// - Eight maskable pins: per-bit enable, edge
// - UART transmit on port 4 bit 3
// - UART receive from P4.2 or P0.2
// - I2C data on P4.0, open drain
// - I2C clock on P4.1, open drain
// - Serial clock tertiary on P4.1 or P4.5
// - Serial data in from P4.0 or P4.4
// - Serial data out on P4.2 or P4.6
// - Pulse channel A on P4.3 or P3.4
// - Pulse channel B on P4.7 or P3.5
// - Pulse channel C on P2.0 or P3.0
// - P4.4 clocks timer A and RC converter B
// - P4.5 clocks timer B and, as tertiary, the serial clock
// - Pulse C clock from P0.2
// - Slow clock P2.0, fast clock P2.1
// - Tone on P2.2, selectable polarity
// - Fast oscillator replaces port 1 bits
// - RC converter B on P4.4 to P4.7
`timescale 1ns/1ps
`default_nettype none
module pfm_port_mux #(
    parameter int P0W = pfm_pkg::P0_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    output logic sys_reset,
    input wire logic nmi_pin,
    output logic nmi_req,
    input wire logic [P0W-1:0] input_port_zero_bits,
    input wire logic [P0W-1:0] ext_irq_en,
    input wire logic [P0W-1:0] ext_irq_fall,
    output logic [P0W-1:0] ext_irq_inputs,
    output logic [P0W-1:0] port0_rd,
    input wire logic [1:0] input_port_one_bits,
    input wire logic [1:0] port1_osc_sel,
    output logic [1:0] port1_rd,
    output logic fast_osc_in,
    input wire logic fast_osc_out,
    output logic fast_osc_out_oe,
    output logic fast_osc_out_pin,
    input wire logic [2:0] port2_wr,
    input wire logic [5:0] port2_sel,
    output logic [2:0] output_port_two_bits,
    input wire logic slow_clock_out,
    input wire logic fast_clock_out,
    input wire logic tone_out,
    input wire logic tone_invert,
    input wire logic [5:0] io_port_three_bits_in,
    output logic [5:0] io_port_three_bits_out,
    output logic [5:0] io_port_three_bits_oe,
    input wire logic [5:0] port3_wr,
    input wire logic [5:0] port3_dir,
    input wire logic [11:0] port3_sel,
    output logic [5:0] port3_rd,
    input wire logic [7:0] io_port_four_bits_in,
    output logic [7:0] io_port_four_bits_out,
    output logic [7:0] io_port_four_bits_oe,
    input wire logic [7:0] port4_wr,
    input wire logic [7:0] port4_dir,
    input wire logic [15:0] port4_sel,
    output logic [7:0] port4_rd,
    input wire logic uart_tx_out,
    output logic uart_rx_in,
    input wire logic i2c_sda_low,
    input wire logic i2c_scl_low,
    output logic i2c_sda_in,
    output logic i2c_scl_in,
    input wire logic sync_serial_clock_out,
    input wire logic sync_serial_clock_oe,
    output logic sync_serial_clock,
    output logic sync_serial_data_in,
    input wire logic sync_serial_data_out,
    input wire logic pulse_out_ch_a,
    input wire logic pulse_out_ch_b,
    input wire logic pulse_out_ch_c,
    output logic timer_a_ext_clock,
    output logic timer_b_ext_clock,
    output logic pulse_c_ext_clock,
    output logic rc_conv_b_osc_in,
    input wire logic rc_conv_b_ref_cap,
    input wire logic rc_conv_b_ref_res,
    input wire logic rc_conv_b_sensor_res
);
    logic [1:0] rst_sync;
    logic nmi_s;
    logic [P0W-1:0] p0_s;
    logic [1:0] p1_s;
    logic [5:0] p3_s;
    logic [7:0] p4_s;
    logic [1:0] s4 [8];
    logic [1:0] s3 [6];
    logic [1:0] s2 [3];
    logic [2:0] p2_nxt;
    logic [5:0] p3_out, p3_oe;
    logic [7:0] p4_out, p4_oe;
    logic [P0W-1:0] irq_pulse;
    logic nmi_pulse;
    logic [2:0] p2_ff;
    logic [5:0] p3_out_ff, p3_oe_ff;
    logic [7:0] p4_out_ff, p4_oe_ff;
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    // Reset pin: two stages, low holds reset
    pfm_sync #(.W(2)) u_sync_rst (
        .clk(clk), .arst_n(arst_n),
        .d({reset_pin_n, nmi_pin}), .q(rst_sync)
    );
    pfm_sync #(.W(P0W)) u_sync_p0 (
        .clk(clk), .arst_n(arst_n),
        .d(input_port_zero_bits), .q(p0_s)
    );
    pfm_sync #(.W(16)) u_sync_p134 (
        .clk(clk), .arst_n(arst_n),
        .d({input_port_one_bits, io_port_three_bits_in,
            io_port_four_bits_in}),
        .q({p1_s, p3_s, p4_s})
    );
    assign nmi_s = rst_sync[0];
    // System reset follows the synchronised reset pin
    assign sys_reset = ~rst_sync[1];
    // ------------------------------------------------------------
    // Function select unpacking
    // ------------------------------------------------------------
    // Two bits per pin; zero means port after reset
    genvar g;
    for (g = 0; g < 8; g++) begin : g_s4
        assign s4[g] = port4_sel[2*g+1:2*g];
    end
    for (g = 0; g < 6; g++) begin : g_s3
        assign s3[g] = port3_sel[2*g+1:2*g];
    end
    for (g = 0; g < 3; g++) begin : g_s2
        assign s2[g] = port2_sel[2*g+1:2*g];
    end
    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Maskable: per-bit enable and edge; non-maskable: both edges
    pfm_edge #(.W(P0W+1)) u_edge (
        .clk(clk), .arst_n(arst_n),
        .lvl({nmi_s, p0_s}),
        .en({1'h1, ext_irq_en}),
        .fall_sel({1'h0, ext_irq_fall}),
        .both({1'h1, {P0W{1'h0}}}),
        .pulse({nmi_pulse, irq_pulse})
    );
    assign nmi_req = nmi_pulse;
    assign ext_irq_inputs = irq_pulse;
    assign port0_rd = p0_s;
    // ------------------------------------------------------------
    // Peripheral inputs from pins
    // ------------------------------------------------------------
    // Port 1: oscillator takes the pin away from the port
    assign port1_rd = p1_s & ~port1_osc_sel;
    assign fast_osc_in = port1_osc_sel[0] & p1_s[0];
    assign fast_osc_out_oe = port1_osc_sel[1];
    assign fast_osc_out_pin = port1_osc_sel[1] & fast_osc_out;
    // UART receive: secondary on P4.2, else primary on P0.2
    assign uart_rx_in = (s4[pfm_pkg::P4_RXD] == pfm_pkg::FN_SECOND) ?
                        p4_s[pfm_pkg::P4_RXD] : p0_s[pfm_pkg::P0_RXD];
    // I2C line levels seen by the controller
    assign i2c_sda_in = p4_s[pfm_pkg::P4_SDA];
    assign i2c_scl_in = p4_s[pfm_pkg::P4_SCL];
    // Serial clock and data in from whichever pin is selected
    assign sync_serial_clock =
        (s4[pfm_pkg::P4_CKB] == pfm_pkg::FN_THIRD) ?
        p4_s[pfm_pkg::P4_CKB] : p4_s[pfm_pkg::P4_SCL];
    assign sync_serial_data_in =
        (s4[pfm_pkg::P4_CKA] == pfm_pkg::FN_THIRD) ?
        p4_s[pfm_pkg::P4_CKA] : p4_s[pfm_pkg::P4_SDA];
    // External clocks on primary function
    assign timer_a_ext_clock = p4_s[pfm_pkg::P4_CKA];
    assign timer_b_ext_clock = p4_s[pfm_pkg::P4_CKB];
    assign pulse_c_ext_clock = p0_s[pfm_pkg::P0_RXD];
    assign rc_conv_b_osc_in = p4_s[pfm_pkg::P4_CKA];
    // ------------------------------------------------------------
    // Port reads: an alternate function masks the port
    // ------------------------------------------------------------
    for (g = 0; g < 8; g++) begin : g_rd4
        assign port4_rd[g] = (s4[g] == pfm_pkg::FN_PORT) & p4_s[g];
    end
    for (g = 0; g < 6; g++) begin : g_rd3
        assign port3_rd[g] = (s3[g] == pfm_pkg::FN_PORT) & p3_s[g];
    end
    // ------------------------------------------------------------
    // Output port 2 next value
    // ------------------------------------------------------------
    always_comb begin
        p2_nxt = port2_wr;
        if (s2[pfm_pkg::P2_SLOW] == pfm_pkg::FN_SECOND) begin
            p2_nxt[pfm_pkg::P2_SLOW] = slow_clock_out;
        end else if (s2[pfm_pkg::P2_SLOW] == pfm_pkg::FN_THIRD) begin
            p2_nxt[pfm_pkg::P2_SLOW] = pulse_out_ch_c;
        end
        if (s2[pfm_pkg::P2_FAST] == pfm_pkg::FN_SECOND) begin
            p2_nxt[pfm_pkg::P2_FAST] = fast_clock_out;
        end
        if (s2[pfm_pkg::P2_TONE] == pfm_pkg::FN_SECOND) begin
            p2_nxt[pfm_pkg::P2_TONE] = tone_out ^ tone_invert;
        end
    end
    // ------------------------------------------------------------
    // Port 3 drive
    // ------------------------------------------------------------
    always_comb begin
        p3_out = port3_wr;
        p3_oe = port3_dir;
        for (int i = 0; i < 6; i++) begin
            if (s3[i] != pfm_pkg::FN_PORT) begin
                p3_out[i] = 1'h0;
                p3_oe[i] = 1'h0;
            end
        end
        if (s3[pfm_pkg::P3_PC] == pfm_pkg::FN_THIRD) begin
            p3_out[pfm_pkg::P3_PC] = pulse_out_ch_c;
            p3_oe[pfm_pkg::P3_PC] = 1'h1;
        end
        if (s3[pfm_pkg::P3_PA] == pfm_pkg::FN_THIRD) begin
            p3_out[pfm_pkg::P3_PA] = pulse_out_ch_a;
            p3_oe[pfm_pkg::P3_PA] = 1'h1;
        end
        if (s3[pfm_pkg::P3_PB] == pfm_pkg::FN_THIRD) begin
            p3_out[pfm_pkg::P3_PB] = pulse_out_ch_b;
            p3_oe[pfm_pkg::P3_PB] = 1'h1;
        end
    end
    // ------------------------------------------------------------
    // Port 4 drive
    // ------------------------------------------------------------
    always_comb begin
        p4_out = port4_wr;
        p4_oe = port4_dir;
        for (int i = 0; i < 8; i++) begin
            if (s4[i] != pfm_pkg::FN_PORT) begin
                p4_out[i] = 1'h0;
                p4_oe[i] = 1'h0;
            end
        end
        // I2C open drain: enable only while pulling low
        if (s4[pfm_pkg::P4_SDA] == pfm_pkg::FN_SECOND) begin
            p4_oe[pfm_pkg::P4_SDA] = i2c_sda_low;
        end
        if (s4[pfm_pkg::P4_SCL] == pfm_pkg::FN_SECOND) begin
            p4_oe[pfm_pkg::P4_SCL] = i2c_scl_low;
        end else if (s4[pfm_pkg::P4_SCL] == pfm_pkg::FN_THIRD) begin
            p4_out[pfm_pkg::P4_SCL] = sync_serial_clock_out;
            p4_oe[pfm_pkg::P4_SCL] = sync_serial_clock_oe;
        end
        if (s4[pfm_pkg::P4_CKB] == pfm_pkg::FN_SECOND) begin
            p4_out[pfm_pkg::P4_CKB] = rc_conv_b_ref_cap;
            p4_oe[pfm_pkg::P4_CKB] = 1'h1;
        end else if (s4[pfm_pkg::P4_CKB] == pfm_pkg::FN_THIRD) begin
            p4_out[pfm_pkg::P4_CKB] = sync_serial_clock_out;
            p4_oe[pfm_pkg::P4_CKB] = sync_serial_clock_oe;
        end
        if (s4[pfm_pkg::P4_RXD] == pfm_pkg::FN_THIRD) begin
            p4_out[pfm_pkg::P4_RXD] = sync_serial_data_out;
            p4_oe[pfm_pkg::P4_RXD] = 1'h1;
        end
        if (s4[pfm_pkg::P4_CKC] == pfm_pkg::FN_SECOND) begin
            p4_out[pfm_pkg::P4_CKC] = rc_conv_b_ref_res;
            p4_oe[pfm_pkg::P4_CKC] = 1'h1;
        end else if (s4[pfm_pkg::P4_CKC] == pfm_pkg::FN_THIRD) begin
            p4_out[pfm_pkg::P4_CKC] = sync_serial_data_out;
            p4_oe[pfm_pkg::P4_CKC] = 1'h1;
        end
        if (s4[pfm_pkg::P4_TXD] == pfm_pkg::FN_SECOND) begin
            p4_out[pfm_pkg::P4_TXD] = uart_tx_out;
            p4_oe[pfm_pkg::P4_TXD] = 1'h1;
        end else if (s4[pfm_pkg::P4_TXD] == pfm_pkg::FN_THIRD) begin
            p4_out[pfm_pkg::P4_TXD] = pulse_out_ch_a;
            p4_oe[pfm_pkg::P4_TXD] = 1'h1;
        end
        if (s4[pfm_pkg::P4_PB] == pfm_pkg::FN_SECOND) begin
            p4_out[pfm_pkg::P4_PB] = rc_conv_b_sensor_res;
            p4_oe[pfm_pkg::P4_PB] = 1'h1;
        end else if (s4[pfm_pkg::P4_PB] == pfm_pkg::FN_THIRD) begin
            p4_out[pfm_pkg::P4_PB] = pulse_out_ch_b;
            p4_oe[pfm_pkg::P4_PB] = 1'h1;
        end
    end
    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Port pins come from flops; reset leaves ports 3 and 4 undriven and drives port 2 low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            p2_ff <= '0;
            p3_out_ff <= '0;
            p3_oe_ff <= '0;
            p4_out_ff <= '0;
            p4_oe_ff <= '0;
        end else begin
            p2_ff <= p2_nxt;
            p3_out_ff <= p3_out;
            p3_oe_ff <= p3_oe;
            p4_out_ff <= p4_out;
            p4_oe_ff <= p4_oe;
        end
    end
    assign output_port_two_bits = p2_ff;
    assign io_port_three_bits_out = p3_out_ff;
    assign io_port_three_bits_oe = p3_oe_ff;
    assign io_port_four_bits_out = p4_out_ff;
    assign io_port_four_bits_oe = p4_oe_ff;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_hold;
        !reset_pin_n [*3] |-> sys_reset;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("reset not held");
    property p_reset_release;
        reset_pin_n [*3] |-> !sys_reset;
    endproperty
    a_reset_release: assert property (p_reset_release)
        else $error("reset not released");
    property p_tx_route;
        s4[pfm_pkg::P4_TXD] == pfm_pkg::FN_SECOND |=>
            io_port_four_bits_out[pfm_pkg::P4_TXD] == $past(uart_tx_out)
            && io_port_four_bits_oe[pfm_pkg::P4_TXD];
    endproperty
    a_tx_route: assert property (p_tx_route)
        else $error("uart tx not routed");
    property p_sda_od;
        s4[pfm_pkg::P4_SDA] == pfm_pkg::FN_SECOND |=>
            !io_port_four_bits_out[pfm_pkg::P4_SDA];
    endproperty
    a_sda_od: assert property (p_sda_od)
        else $error("sda driven high");
    property p_scl_od;
        s4[pfm_pkg::P4_SCL] == pfm_pkg::FN_SECOND |=>
            io_port_four_bits_oe[pfm_pkg::P4_SCL] == $past(i2c_scl_low);
    endproperty
    a_scl_od: assert property (p_scl_od)
        else $error("scl drive wrong");
    property p_tone_pol;
        s2[pfm_pkg::P2_TONE] == pfm_pkg::FN_SECOND |=>
            output_port_two_bits[pfm_pkg::P2_TONE] ==
            ($past(tone_out) ^ $past(tone_invert));
    endproperty
    a_tone_pol: assert property (p_tone_pol)
        else $error("tone polarity wrong");
    property p_port_mask;
        s4[pfm_pkg::P4_TXD] != pfm_pkg::FN_PORT |-> !port4_rd[3];
    endproperty
    a_port_mask: assert property (p_port_mask)
        else $error("port read not masked");
endmodule : pfm_port_mux
`default_nettype wire

// ===== pfm_board.sv
// Board model of the port pins: pull-ups and external drivers
`timescale 1ns/1ps
`default_nettype none
module pfm_board (
    input wire logic [7:0] p4_out,
    input wire logic [7:0] p4_oe,
    input wire logic [5:0] p3_out,
    input wire logic [5:0] p3_oe,
    input wire logic [7:0] p4_ext,
    input wire logic [5:0] p3_ext,
    output logic [7:0] p4_pin,
    output logic [5:0] p3_pin
);
    // Two-wire bus lines rise through resistors once released
    assign p4_pin = (p4_oe & p4_out) | (~p4_oe & (p4_ext | 8'h03));
    // Other lines follow the board driver when the device lets go
    assign p3_pin = (p3_oe & p3_out) | (~p3_oe & p3_ext);
endmodule : pfm_board
`default_nettype wire

// ===== test_port_function_mux.sv
// Self-checking bench of the port function multiplexer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    err_count++; $display("CHECK FAILED at %0t: got %h want %h", \
    $time, a, b); end end
module test_port_function_mux;
    logic clk, arst_n, reset_pin_n, sys_reset, nmi_pin, nmi_req;
    logic [7:0] input_port_zero_bits, ext_irq_en, ext_irq_fall;
    logic [7:0] ext_irq_inputs, port0_rd;
    logic [1:0] input_port_one_bits, port1_osc_sel, port1_rd;
    logic fast_osc_in, fast_osc_out, fast_osc_out_oe, fast_osc_out_pin;
    logic [2:0] port2_wr, output_port_two_bits;
    logic [5:0] port2_sel, io_port_three_bits_in, io_port_three_bits_out;
    logic [5:0] io_port_three_bits_oe, port3_wr, port3_dir, port3_rd, ext3;
    logic [11:0] port3_sel;
    logic slow_clock_out, fast_clock_out, tone_out, tone_invert;
    logic [7:0] io_port_four_bits_in, io_port_four_bits_out, ext4;
    logic [7:0] io_port_four_bits_oe, port4_wr, port4_dir, port4_rd;
    logic [15:0] port4_sel;
    logic uart_tx_out, uart_rx_in, i2c_sda_low, i2c_scl_low;
    logic i2c_sda_in, i2c_scl_in, sync_serial_clock_out;
    logic sync_serial_clock_oe, sync_serial_clock, sync_serial_data_in;
    logic sync_serial_data_out, pulse_out_ch_a, pulse_out_ch_b;
    logic pulse_out_ch_c, timer_a_ext_clock, timer_b_ext_clock;
    logic pulse_c_ext_clock, rc_conv_b_osc_in, rc_conv_b_ref_cap;
    logic rc_conv_b_ref_res, rc_conv_b_sensor_res;
    int err_count = 0;
    int samples_checked = 0;
    int nmi_cnt = 0;
    int irq_hits = 0;
    int base;

    pfm_port_mux dut_u (.*);
    pfm_board board_u (.p4_out(io_port_four_bits_out),
        .p4_oe(io_port_four_bits_oe), .p3_out(io_port_three_bits_out),
        .p3_oe(io_port_three_bits_oe), .p4_ext(ext4), .p3_ext(ext3),
        .p4_pin(io_port_four_bits_in), .p3_pin(io_port_three_bits_in));

    // Clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Request pulse counters
    always @(posedge clk) begin
        nmi_cnt <= nmi_cnt + int'(nmi_req === 1'b1);
        irq_hits <= irq_hits + $countones(ext_irq_inputs);
    end

    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask : settle

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic t_reset;
        settle();
        `CHK(sys_reset, 1'b1)
        `CHK(io_port_four_bits_oe, 8'h00)
        `CHK(io_port_three_bits_oe, 6'h00)
        @(posedge clk) reset_pin_n <= 1'b1;
        settle();
        `CHK(sys_reset, 1'b0)
        $display("reset test done");
    endtask : t_reset

    task automatic t_irq;
        base = nmi_cnt;
        @(posedge clk) nmi_pin <= 1'b1;
        settle();
        @(posedge clk) nmi_pin <= 1'b0;
        settle();
        `CHK(nmi_cnt - base, 2)
        base = irq_hits;
        @(posedge clk) ext_irq_en <= 8'h3C;
        ext_irq_fall <= 8'hAA;
        input_port_zero_bits <= 8'hFF;
        settle();
        `CHK(irq_hits - base, 2)
        `CHK(port0_rd, 8'hFF)
        @(posedge clk) input_port_zero_bits <= 8'h00;
        settle();
        `CHK(irq_hits - base, 4)
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_uart;
        @(posedge clk) port4_sel <= 16'h0050;
        uart_tx_out <= 1'b1;
        ext4 <= 8'h04;
        settle();
        `CHK(io_port_four_bits_out[3], 1'b1)
        `CHK(io_port_four_bits_oe[3], 1'b1)
        `CHK(uart_rx_in, 1'b1)
        `CHK(port4_rd[2], 1'b0)
        @(posedge clk) port4_sel <= 16'h0000;
        ext4 <= 8'h00;
        input_port_zero_bits <= 8'h04;
        settle();
        `CHK(uart_rx_in, 1'b1)
        `CHK(pulse_c_ext_clock, 1'b1)
        `CHK(io_port_four_bits_oe[3], 1'b0)
        @(posedge clk) input_port_zero_bits <= 8'h00;
        $display("uart test done");
    endtask : t_uart

    task automatic t_i2c;
        @(posedge clk) port4_sel <= 16'h0005;
        port4_dir <= 8'h03;
        port4_wr <= 8'h03;
        i2c_sda_low <= 1'b1;
        settle();
        `CHK(io_port_four_bits_oe[1:0], 2'h1)
        `CHK(io_port_four_bits_out[0], 1'b0)
        `CHK({i2c_scl_in, i2c_sda_in}, 2'h2)
        @(posedge clk) i2c_sda_low <= 1'b0;
        i2c_scl_low <= 1'b1;
        settle();
        `CHK(io_port_four_bits_oe[1:0], 2'h2)
        `CHK(io_port_four_bits_out[1], 1'b0)
        `CHK({i2c_scl_in, i2c_sda_in}, 2'h1)
        @(posedge clk) port4_dir <= 8'h00;
        i2c_scl_low <= 1'b0;
        $display("two-wire test done");
    endtask : t_i2c

    task automatic t_third;
        @(posedge clk) port4_sel <= 16'hAA80;
        port3_sel <= 12'hA02;
        port2_sel <= 6'h02;
        {pulse_out_ch_a, pulse_out_ch_b, pulse_out_ch_c} <= 3'h5;
        {sync_serial_data_out, sync_serial_clock_oe} <= 2'h3;
        sync_serial_clock_out <= 1'b1;
        settle();
        `CHK(io_port_four_bits_oe, 8'hE8)
        `CHK(io_port_four_bits_out[7:5], 3'h3)
        `CHK(io_port_four_bits_out[3], 1'b1)
        `CHK(io_port_three_bits_oe, 6'h31)
        `CHK(io_port_three_bits_out[5:4], 2'h1)
        `CHK(io_port_three_bits_out[0], 1'b1)
        `CHK(output_port_two_bits[0], 1'b1)
        @(posedge clk) {pulse_out_ch_a, pulse_out_ch_b} <= 2'h1;
        {pulse_out_ch_c, sync_serial_clock_oe} <= 2'h0;
        ext4 <= 8'h30;
        port4_wr <= 8'h00;
        port4_dir <= 8'h03;
        ext3 <= 6'h3F;
        settle();
        `CHK(io_port_four_bits_out[7], 1'b1)
        `CHK(port3_rd, 6'h0E)
        `CHK(io_port_three_bits_out[4], 1'b0)
        `CHK({sync_serial_clock, sync_serial_data_in}, 2'h3)
        `CHK(output_port_two_bits[0], 1'b0)
        `CHK(io_port_four_bits_oe[5], 1'b0)
        $display("tertiary test done");
    endtask : t_third

    task automatic t_out2;
        @(posedge clk) port2_sel <= 6'h15;
        {slow_clock_out, fast_clock_out, tone_out} <= 3'h5;
        tone_invert <= 1'b1;
        settle();
        `CHK(output_port_two_bits, 3'h1)
        @(posedge clk) {slow_clock_out, fast_clock_out} <= 2'h1;
        tone_invert <= 1'b0;
        settle();
        `CHK(output_port_two_bits, 3'h6)
        @(posedge clk) port2_sel <= 6'h00;
        port2_wr <= 3'h5;
        settle();
        `CHK(output_port_two_bits, 3'h5)
        $display("output port test done");
    endtask : t_out2

    task automatic t_conv;
        @(posedge clk) port4_sel <= 16'h5500;
        {rc_conv_b_ref_cap, rc_conv_b_ref_res} <= 2'h1;
        rc_conv_b_sensor_res <= 1'b1;
        ext4 <= 8'h10;
        {port1_osc_sel, input_port_one_bits, fast_osc_out} <= 5'h1F;
        settle();
        `CHK(io_port_four_bits_oe[7:5], 3'h7)
        `CHK(io_port_four_bits_out[7:5], 3'h6)
        `CHK(rc_conv_b_osc_in, 1'b1)
        `CHK(port1_rd, 2'h0)
        `CHK(fast_osc_in, 1'b1)
        `CHK({fast_osc_out_oe, fast_osc_out_pin}, 2'h3)
        @(posedge clk) port4_sel <= 16'h0000;
        ext4 <= 8'h30;
        port1_osc_sel <= 2'h0;
        settle();
        `CHK({timer_b_ext_clock, timer_a_ext_clock}, 2'h3)
        `CHK(port4_rd[5:4], 2'h3)
        `CHK(port1_rd, 2'h3)
        `CHK({fast_osc_out_oe, fast_osc_out_pin}, 2'h0)
        $display("converter test done");
    endtask : t_conv

    // Watchdog against a hung run
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        {arst_n, reset_pin_n, nmi_pin, fast_osc_out} = 4'h0;
        {input_port_zero_bits, ext_irq_en, ext_irq_fall} = 24'h0;
        {input_port_one_bits, port1_osc_sel, port2_wr, port2_sel} = 13'h0;
        {slow_clock_out, fast_clock_out, tone_out, tone_invert} = 4'h0;
        {port3_wr, port3_dir, port3_sel, ext3} = 30'h0;
        {port4_wr, port4_dir, port4_sel, ext4} = 40'h0;
        {uart_tx_out, i2c_sda_low, i2c_scl_low} = 3'h0;
        {sync_serial_clock_out, sync_serial_clock_oe} = 2'h0;
        {sync_serial_data_out, pulse_out_ch_a, pulse_out_ch_b} = 3'h0;
        {pulse_out_ch_c, rc_conv_b_ref_cap, rc_conv_b_ref_res} = 3'h0;
        rc_conv_b_sensor_res = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_irq();
        t_uart();
        t_i2c();
        t_third();
        t_out2();
        t_conv();
        give_verdict();
    end
endmodule : test_port_function_mux
`default_nettype wire
